// ==== design/nfc_pkg.sv ====
// Constants and types for the numeric format converter datapath.
// Assumes a single clock domain shared with the instruction sequencer.
package nfc_pkg;

  // ---------------------------------------------------------------
  // Operations and states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    dword_to_word_op  = 4'h0,
    word_to_dword_op  = 4'h1,
    byte_to_word_op   = 4'h2,
    word_to_byte_op   = 4'h3,
    real_round_op     = 4'h4,
    real_truncate_op  = 4'h5,
    segment_encode_op = 4'h6,
    ascii_to_hex_op   = 4'h7,
    hex_to_ascii_op   = 4'h8,
    word_to_text_op   = 4'h9,
    dword_to_text_op  = 4'ha,
    real_to_text_op   = 4'hb
  } nfc_op_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN  = 2'h1
  } nfc_state_type;

  // ---------------------------------------------------------------
  // Error codes, characters, fields
  // ---------------------------------------------------------------
  localparam logic [15:0] ERR_NONE     = 16'h0000;
  localparam logic [15:0] ERR_IND_ADDR = 16'h0006;
  localparam logic [15:0] ERR_RANGE    = 16'h0091;

  localparam int          TEXT_LEN     = 8;
  localparam logic [2:0]  MAX_FRAC     = 3'h5;
  localparam int          FMT_SEP_BIT  = 3;

  localparam logic [7:0]  CH_ZERO      = 8'h30;
  localparam logic [7:0]  CH_NINE      = 8'h39;
  localparam logic [7:0]  CH_A         = 8'h41;
  localparam logic [7:0]  CH_F         = 8'h46;
  localparam logic [7:0]  CH_SPACE     = 8'h20;
  localparam logic [7:0]  CH_MINUS     = 8'h2d;
  localparam logic [7:0]  CH_COMMA     = 8'h2c;
  localparam logic [7:0]  CH_PERIOD    = 8'h2e;
  localparam logic [7:0]  HEX_TEN      = 8'h0a;

  // Exponent limits of a single-precision real
  localparam logic [7:0]  EXP_INVALID  = 8'hff;
  localparam logic [7:0]  EXP_SMALL    = 8'h76;
  localparam logic [7:0]  EXP_TOO_BIG  = 8'h9f;

  // Segment patterns, bit 0 = segment a
  localparam logic [7:0]  SEG_TABLE [16] = '{
    8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
    8'h7f, 8'h67, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71
  };

  // Values after reset
  localparam logic [31:0] RST_RESULT   = 32'h0000_0000;
  localparam logic [63:0] RST_TEXT     = 64'h2020_2020_2020_2020;
  localparam logic [7:0]  RST_BYTE     = 8'h00;

endpackage

// ==== design/nfc_converter.sv ====
// Conversion datapath of the controller instruction executor.
// Assumes the sequencer runs on i_sys_clk and holds inputs stable.

// What this block does
// - Dword narrowing overflow: flag, keep result, eno low
// - Word widening replicates the sign bit
// - Byte widening is unsigned, zero filled
// - Word to byte only 0..255, else overflow
// - Round up when fraction is half or more
// - Truncate keeps only whole part
// - Invalid real, result over 7FFFFFFF, or negative real of magnitude 2^32 or more: overflow, keep, eno low
// - Bad indirect address: eno low, code 0006
// - Segment uses low nibble only
// - Segment bit order and patterns 0..7
// - Segment patterns for nibbles 8..F
// - Valid hex characters 30-39, 41-46 only
// - Char count sets element count, max 255
// - ASCII to hex flags illegal character
// - Range exceeded: eno low, code 0091
// - Text output is always eight characters
// - Format upper nibble nonzero: illegal format
// - Zero fraction digits: no separator
// - Fraction count over five: all spaces
// - Separator comma when set, period when clear
// - Minus sign only before negative leading digit
// - Suppress leading zeros, right justify text
module nfc_converter
  import nfc_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_valid,
  input  wire nfc_op_type  i_opcode,
  input  wire logic [31:0] i_operand,
  input  wire logic [7:0]  i_char_count,
  input  wire logic [7:0]  i_format_byte,
  input  wire logic        i_addr_err,
  input  wire logic        i_range_err,
  input  wire logic [7:0]  i_elem_data,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_dest_write,
  output logic [31:0]      o_result,
  output logic [63:0]      o_text,
  output logic             o_enable_out,
  output logic [15:0]      o_error_code,
  output logic             o_overflow_flag,
  output logic             o_illegal_ascii_flag,
  output logic             o_illegal_format,
  output logic [7:0]       o_elem_index,
  output logic             o_elem_valid,
  output logic [7:0]       o_elem_out
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [32:0] real_to_int(logic [31:0] r, logic rnd);
    logic [63:0] q;
    logic [32:0] mag;
    logic        ovf;
    q   = '0;
    mag = '0;
    ovf = 1'b0;
    if (r[30:23] == EXP_INVALID || r[30:23] >= EXP_TOO_BIG) begin
      ovf = 1'b1;
    end else if (r[30:23] >= EXP_SMALL) begin
      q   = 64'({1'b1, r[22:0]}) << (r[30:23] - EXP_SMALL);
      mag = {1'b0, q[63:32]} + 33'(rnd & q[31]);
    end
    if (mag > (r[31] ? 33'h1_0000_0000 : 33'h0_7fff_ffff)) begin
      ovf = 1'b1;
    end
    return {ovf, (r[31] ? 32'(-mag) : mag[31:0])};
  endfunction

  function automatic logic [63:0] fmt_text(logic [15:0] v, logic [2:0] n,
                                           logic c);
    logic [16:0] rem;
    logic [63:0] t;
    logic [3:0]  di;
    logic        sepd;
    logic        fin;
    t    = RST_TEXT;
    rem  = v[15] ? 17'(-{v[15], v}) : {1'b0, v};
    di   = 4'h0;
    sepd = (n == 3'h0);
    fin  = 1'b0;
    for (int p = TEXT_LEN - 1; p >= 0; p--) begin
      if (!fin) begin
        if (di == {1'b0, n} && !sepd) begin
          t[p*8 +: 8] = c ? CH_COMMA : CH_PERIOD;
          sepd = 1'b1;
        end else if (di <= {1'b0, n} || rem != 17'h00000) begin
          t[p*8 +: 8] = CH_ZERO + 8'(rem % 17'h0000a);
          rem = rem / 17'h0000a;
          di  = di + 4'h1;
        end else begin
          if (v[15]) begin
            t[p*8 +: 8] = CH_MINUS;
          end
          fin = 1'b1;
        end
      end
    end
    return t;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  nfc_state_type state_ff, nxt_state;
  nfc_op_type    op_ff, nxt_op;
  logic [7:0]    count_ff, nxt_count;
  logic [7:0]    index_ff, nxt_index;
  logic          done_ff, nxt_done;
  logic          write_ff, nxt_write;
  logic          eno_ff, nxt_eno;
  logic [15:0]   err_ff, nxt_err;
  logic [31:0]   result_ff, nxt_result;
  logic [63:0]   text_ff, nxt_text;
  logic          ovf_ff, nxt_ovf;
  logic          ill_ff, nxt_ill;
  logic          fmt_err_ff, nxt_fmt_err;
  logic          elem_valid_ff, nxt_elem_valid;
  logic [7:0]    elem_out_ff, nxt_elem_out;
  logic [32:0]   conv;
  logic          take;
  logic          chr_ok;

  assign take   = i_valid && state_ff == ST_IDLE;
  assign chr_ok = (i_elem_data >= CH_ZERO && i_elem_data <= CH_NINE) ||
                  (i_elem_data >= CH_A && i_elem_data <= CH_F);

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state      = state_ff;
    nxt_op         = op_ff;
    nxt_count      = count_ff;
    nxt_index      = index_ff;
    nxt_done       = 1'b0;
    nxt_write      = 1'b0;
    nxt_eno        = eno_ff;
    nxt_err        = err_ff;
    nxt_result     = result_ff;
    nxt_text       = text_ff;
    nxt_ovf        = ovf_ff;
    nxt_ill        = ill_ff;
    nxt_fmt_err    = fmt_err_ff;
    nxt_elem_valid = 1'b0;
    nxt_elem_out   = elem_out_ff;
    conv = real_to_int(i_operand, i_opcode == real_round_op);
    unique case (state_ff)
      ST_IDLE: if (i_valid) begin
        nxt_eno     = 1'b1;
        nxt_err     = ERR_NONE;
        nxt_fmt_err = 1'b0;
        nxt_op      = i_opcode;
        nxt_done    = 1'b1;
        if (i_addr_err) begin
          nxt_eno = 1'b0;
          nxt_err = ERR_IND_ADDR;
        end else begin
          unique case (i_opcode)
            dword_to_word_op: begin
              nxt_ovf = !(&i_operand[31:15] || ~|i_operand[31:15]);
              nxt_eno = !nxt_ovf;
              if (!nxt_ovf) begin
                nxt_result = {16'h0000, i_operand[15:0]};
                nxt_write  = 1'b1;
              end
            end
            word_to_dword_op: begin
              nxt_result = {{16{i_operand[15]}}, i_operand[15:0]};
              nxt_write  = 1'b1;
            end
            byte_to_word_op: begin
              nxt_result = {24'h000000, i_operand[7:0]};
              nxt_write  = 1'b1;
            end
            word_to_byte_op: begin
              nxt_ovf = |i_operand[15:8];
              nxt_eno = !nxt_ovf;
              if (!nxt_ovf) begin
                nxt_result = {24'h000000, i_operand[7:0]};
                nxt_write  = 1'b1;
              end
            end
            real_round_op, real_truncate_op: begin
              nxt_ovf = conv[32];
              nxt_eno = !conv[32];
              if (!conv[32]) begin
                nxt_result = conv[31:0];
                nxt_write  = 1'b1;
              end
            end
            segment_encode_op: begin
              nxt_result = {24'h000000, SEG_TABLE[i_operand[3:0]]};
              nxt_write  = 1'b1;
            end
            ascii_to_hex_op, hex_to_ascii_op: begin
              if (i_opcode == ascii_to_hex_op) begin
                nxt_ill = 1'b0;
              end
              if (i_range_err) begin
                nxt_eno = 1'b0;
                nxt_err = ERR_RANGE;
              end else if (i_char_count != RST_BYTE) begin
                nxt_done  = 1'b0;
                nxt_state = ST_RUN;
                nxt_count = i_char_count;
                nxt_index = RST_BYTE;
              end
            end
            word_to_text_op: begin
              if (|i_format_byte[7:4]) begin
                nxt_fmt_err = 1'b1;
                nxt_eno     = 1'b0;
              end else if (i_format_byte[2:0] > MAX_FRAC) begin
                nxt_text  = RST_TEXT;
                nxt_eno   = 1'b0;
                nxt_write = 1'b1;
              end else begin
                nxt_text  = fmt_text(i_operand[15:0], i_format_byte[2:0],
                                     i_format_byte[FMT_SEP_BIT]);
                nxt_write = 1'b1;
              end
            end
            default: begin
              nxt_eno = 1'b0;
            end
          endcase
        end
      end
      ST_RUN: begin
        nxt_index      = index_ff + 8'h01;
        nxt_count      = count_ff - 8'h01;
        nxt_elem_valid = 1'b1;
        if (op_ff == ascii_to_hex_op) begin
          nxt_elem_out = i_elem_data - ((i_elem_data <= CH_NINE) ?
                         CH_ZERO : (CH_A - HEX_TEN));
          if (!chr_ok) begin
            nxt_ill        = 1'b1;
            nxt_eno        = 1'b0;
            nxt_elem_valid = 1'b0;
            nxt_done       = 1'b1;
            nxt_state      = ST_IDLE;
          end
        end else begin
          nxt_elem_out = {4'h0, i_elem_data[3:0]} +
                         ((i_elem_data[3:0] < 4'ha) ? CH_ZERO :
                          (CH_A - HEX_TEN));
        end
        if (count_ff == 8'h01 && nxt_state == ST_RUN) begin
          nxt_done  = 1'b1;
          nxt_write = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Sequencing registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_IDLE;
      op_ff    <= dword_to_word_op;
      count_ff <= RST_BYTE;
      index_ff <= RST_BYTE;
      done_ff  <= 1'b0;
      write_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      op_ff    <= nxt_op;
      count_ff <= nxt_count;
      index_ff <= nxt_index;
      done_ff  <= nxt_done;
      write_ff <= nxt_write;
    end
  end

  // ---------------------------------------------------------------
  // Result and status registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      result_ff     <= RST_RESULT;
      text_ff       <= RST_TEXT;
      eno_ff        <= 1'b0;
      err_ff        <= ERR_NONE;
      ovf_ff        <= 1'b0;
      ill_ff        <= 1'b0;
      fmt_err_ff    <= 1'b0;
      elem_valid_ff <= 1'b0;
      elem_out_ff   <= RST_BYTE;
    end else begin
      result_ff     <= nxt_result;
      text_ff       <= nxt_text;
      eno_ff        <= nxt_eno;
      err_ff        <= nxt_err;
      ovf_ff        <= nxt_ovf;
      ill_ff        <= nxt_ill;
      fmt_err_ff    <= nxt_fmt_err;
      elem_valid_ff <= nxt_elem_valid;
      elem_out_ff   <= nxt_elem_out;
    end
  end

  assign o_busy               = state_ff[0];
  assign o_done               = done_ff;
  assign o_dest_write         = write_ff;
  assign o_result             = result_ff;
  assign o_text               = text_ff;
  assign o_enable_out         = eno_ff;
  assign o_error_code         = err_ff;
  assign o_overflow_flag      = ovf_ff;
  assign o_illegal_ascii_flag = ill_ff;
  assign o_illegal_format     = fmt_err_ff;
  assign o_elem_index         = index_ff;
  assign o_elem_valid         = elem_valid_ff;
  assign o_elem_out           = elem_out_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_narrow_dword_ovf: assert property (
    take && !i_addr_err && i_opcode == dword_to_word_op &&
    !(&i_operand[31:15] || ~|i_operand[31:15]) |=>
    o_overflow_flag && !o_enable_out && !o_dest_write && $stable(o_result))
    else $error("dword narrowing overflow not handled");
  a_widen_sign_ext: assert property (
    take && !i_addr_err && i_opcode == word_to_dword_op |=>
    o_result == {{16{$past(i_operand[15])}}, $past(i_operand[15:0])})
    else $error("sign not extended");
  a_widen_byte_zero: assert property (
    take && !i_addr_err && i_opcode == byte_to_word_op |=>
    o_result[31:8] == 24'h000000 && o_dest_write)
    else $error("byte widening not zero filled");
  a_narrow_byte_ovf: assert property (
    take && !i_addr_err && i_opcode == word_to_byte_op &&
    |i_operand[15:8] |=> o_overflow_flag && $stable(o_result))
    else $error("byte narrowing overflow not handled");
  a_round_half_up: assert property (
    take && !i_addr_err && i_opcode == real_round_op &&
    i_operand == 32'h3f00_0000 |=> o_result == 32'h0000_0001)
    else $error("half did not round up");
  a_bad_address: assert property (
    take && i_addr_err |=> o_done && !o_enable_out &&
    o_error_code == ERR_IND_ADDR && !o_dest_write)
    else $error("indirect address error not reported");
  a_segment_code: assert property (
    take && !i_addr_err && i_opcode == segment_encode_op |=>
    o_result[7:0] == SEG_TABLE[$past(i_operand[3:0])])
    else $error("segment pattern wrong");
  a_ascii_illegal: assert property (
    state_ff == ST_RUN && op_ff == ascii_to_hex_op && !chr_ok |=>
    o_illegal_ascii_flag && !o_enable_out && o_done && !o_busy)
    else $error("illegal character not flagged");
  a_spaces_fill: assert property (
    take && !i_addr_err && i_opcode == word_to_text_op &&
    i_format_byte[7:3] == 5'h00 && i_format_byte[2:0] > MAX_FRAC |=>
    o_text == RST_TEXT && !o_enable_out)
    else $error("text not filled with spaces");
  a_done_single: assert property (
    o_done && !take |=> !o_done)
    else $error("done longer than one cycle");

  c_text_done: cover property (
    take && i_opcode == word_to_text_op ##1 o_done && o_enable_out);
  c_hex_run: cover property (
    take && i_opcode == ascii_to_hex_op ##1 o_busy ##[1:8] o_done);
  c_round_ovf: cover property (
    take && i_opcode == real_round_op ##1 o_overflow_flag);

endmodule

// ==== dv/nfc_seq_model.sv ====
// Sequencer model: hands element bytes to the converter by index.
// Assumes the converter shares i_sys_clk with the bench.
module nfc_seq_model (
  input  wire logic       i_sys_clk,
  input  wire logic       i_busy,
  input  wire logic [7:0] i_elem_index,
  output logic      [7:0] o_elem_data
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [256];
  logic [7:0] last_ff = 8'h00;

  // ----------------
  // Element source
  // ----------------
  always_ff @(posedge i_sys_clk) begin
    last_ff <= o_elem_data;
  end

  // Idle data toggles so a stale byte never looks valid
  always_comb begin
    o_elem_data = i_busy ? mem[i_elem_index] : ~last_ff;
  end
endmodule

// ==== dv/nfc_converter_test.sv ====
// Self-checking bench for the conversion datapath.
// Assumes nfc_pkg, nfc_converter and nfc_seq_model are compiled first.
module nfc_converter_test;
  import nfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------
  // Signals and tables
  // ----------------
  logic        clk, rst_n, valid, ae, re, ok;
  nfc_op_type  op;
  logic [31:0] operand, res, exp_res;
  logic [7:0]  cnt, fmt, edata, eidx, eout, f;
  logic [15:0] code, w;
  logic [63:0] text;
  logic        busy, done, dwr, enable_out, ovf, ill, ifmt, evld;
  int          err_total, n_checks, nel, i, j, t;
  int          cycles = 0;

  localparam logic [7:0] SEGS [16] = '{
    8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07,
    8'h7f, 8'h67, 8'h77, 8'h7c, 8'h39, 8'h5e, 8'h79, 8'h71};
  localparam real RTAB [9] = '{2.5, -2.5, 1.49, -7.75, 123456.0,
    3.0e9, -2147483648.0, 0.5, 0.0};
  localparam logic [7:0] CHRS [9] = '{8'h2f, 8'h30, 8'h39, 8'h3a,
    8'h40, 8'h41, 8'h46, 8'h47, 8'h61};
  localparam logic [23:0] TXC [5] = '{24'h000c03, 24'hff8503,
    24'hcfc703, 24'h800005, 24'h000000};
  localparam logic [31:0] NCOR [6] = '{32'h00007fff, 32'hffff8000,
    32'h00008000, 32'h000000ff, 32'h00000100, 32'hffff7fff};
  localparam logic [7:0] FBAD [4] = '{8'h06, 8'h0f, 8'h13, 8'h83};
  localparam nfc_op_type NOPS [5] = '{dword_to_word_op,
    word_to_dword_op, byte_to_word_op, word_to_byte_op,
    segment_encode_op};

  nfc_converter uut (
    .i_sys_clk            (clk),
    .i_rst_n              (rst_n),
    .i_valid              (valid),
    .i_opcode             (op),
    .i_operand            (operand),
    .i_char_count         (cnt),
    .i_format_byte        (fmt),
    .i_addr_err           (ae),
    .i_range_err          (re),
    .i_elem_data          (edata),
    .o_busy               (busy),
    .o_done               (done),
    .o_dest_write         (dwr),
    .o_result             (res),
    .o_text               (text),
    .o_enable_out         (enable_out),
    .o_error_code         (code),
    .o_overflow_flag      (ovf),
    .o_illegal_ascii_flag (ill),
    .o_illegal_format     (ifmt),
    .o_elem_index         (eidx),
    .o_elem_valid         (evld),
    .o_elem_out           (eout)
  );

  nfc_seq_model mdl (
    .i_sys_clk    (clk),
    .i_busy       (busy),
    .i_elem_index (eidx),
    .o_elem_data  (edata)
  );

  always #12.5 clk = ~clk;

  // ----------------
  // Expectations
  // ----------------
  function automatic logic [7:0] exp_el(nfc_op_type o, logic [7:0] d);
    if (o == ascii_to_hex_op) return (d <= 8'h39) ? d - 8'h30 : d - 8'h37;
    return (d[3:0] < 4'ha) ? {4'h3, d[3:0]} : {4'h0, d[3:0]} + 8'h37;
  endfunction

  function automatic logic [63:0] txt(logic [15:0] v, int n, logic c);
    logic [63:0] s;
    int m, p, k;
    s = {8{8'h20}};
    m = $signed(v);
    if (m < 0) m = -m;
    p = 7;
    k = 0;
    do begin
      if (n > 0 && k == n) begin
        s[p*8 +: 8] = c ? 8'h2c : 8'h2e;
        p--;
      end
      s[p*8 +: 8] = 8'h30 + 8'(m % 10);
      m = m / 10;
      p--;
      k++;
    end while (m != 0 || k <= n);
    if ($signed(v) < 0) s[p*8 +: 8] = 8'h2d;
    return s;
  endfunction

  // Single precision bits of a real, mantissa cut short
  function automatic logic [31:0] sp(real r);
    logic [63:0] b;
    b = $realtobits(r);
    return {b[63], 8'(b[62:52] - 11'h380), b[51:29]};
  endfunction

  // ----------------
  // Tasks
  // ----------------
  task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic run(nfc_op_type o, logic [31:0] d, logic [7:0] n,
                     logic [7:0] fb, logic a, logic b);
    int k;
    valid = 1'b1;
    op = o;
    operand = d;
    cnt = n;
    fmt = fb;
    ae = a;
    re = b;
    nel = 0;
    for (k = 0; k < 400; k++) begin
      @(posedge clk);
      #2;
      if (evld === 1'b1) begin
        check("elem", eout, exp_el(o, mdl.mem[nel]));
        nel++;
      end
      if (done === 1'b1) break;
    end
    if (k == 400) begin
      err_total++;
      finish_test();
    end
    check("busy", busy, 1'b0);
  endtask

  task automatic num_op(int k, logic [31:0] v);
    logic [31:0] x;
    logic of;
    of = 1'b0;
    x = {24'h0, v[7:0]};
    if (k == 0) of = !(v[31:15] == 17'h0 || v[31:15] == 17'h1ffff);
    if (k == 0) x = {16'h0, v[15:0]};
    if (k == 1) x = {{16{v[15]}}, v[15:0]};
    if (k == 3) of = v[15:8] != 8'h00;
    if (k == 4) x = {24'h0, SEGS[v[3:0]]};
    if (of) x = exp_res;
    run(NOPS[k], v, 8'h00, 8'h00, 1'b0, 1'b0);
    check("result", res, x);
    check("eno", {enable_out, dwr}, {!of, !of});
    if (k == 0 || k == 3) check("overflow", ovf, of);
    exp_res = x;
  endtask

  task automatic real_op(int jj, int tt);
    real rv, x;
    logic of;
    logic [31:0] d;
    num_op(1, $urandom);
    rv = RTAB[jj];
    d = (jj == 8) ? 32'h7fc00000 : sp(rv);
    x = (rv >= 0) ? $floor(rv + 0.5) : -$floor(0.5 - rv);
    if (tt == 1) x = (rv >= 0) ? $floor(rv) : -$floor(-rv);
    of = jj == 8 || x > 2147483647.0 || x < -2147483648.0;
    if (!of) exp_res = 32'(longint'(x));
    run(tt ? real_truncate_op : real_round_op, d, 8'h00, 8'h00, 1'b0, 1'b0);
    check("real result", res, exp_res);
    check("real flags", {ovf, enable_out}, {of, !of});
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      finish_test();
    end
  end

  // ----------------
  // Main sequence
  // ----------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    valid = 1'b0;
    op = dword_to_word_op;
    operand = 32'h0;
    cnt = 8'h00;
    fmt = 8'h00;
    ae = 1'b0;
    re = 1'b0;
    err_total = 0;
    n_checks = 0;
    exp_res = 32'h0;
    void'($urandom(5945));
    repeat (5) @(posedge clk);
    #2;
    rst_n = 1'b1;
    check("reset text", text, {8{8'h20}});
    check("reset out", {res, done, enable_out, ovf, ill}, 36'h0);
    for (i = 0; i < 6; i++) begin
      num_op(0, NCOR[i]);
      num_op(3, NCOR[i]);
    end
    for (i = 0; i < 80; i++) num_op($urandom % 5, $urandom);
    for (i = 0; i < 16; i++) num_op(4, {28'($urandom), 4'(i)});
    for (j = 0; j < 9; j++) for (t = 0; t < 2; t++) real_op(j, t);
    for (i = 0; i < 10; i++) begin
      run(nfc_op_type'(i), $urandom, 8'h03, 8'h00, 1'b1, 1'b0);
      check("addr eno", {enable_out, dwr, 8'(nel)}, 10'h0);
      check("addr code", code, 16'h0006);
    end
    for (i = 7; i < 9; i++) begin
      run(nfc_op_type'(i), 32'h0, 8'h04, 8'h00, 1'b0, 1'b1);
      check("range", {enable_out, code}, {1'b0, 16'h0091});
    end
    for (i = 10; i < 12; i++) begin
      run(nfc_op_type'(i), $urandom, 8'h00, 8'h00, 1'b0, 1'b0);
      check("unsupported", {enable_out, dwr, code}, 18'h00000);
    end
    for (i = 0; i < 9; i++) begin
      ok = CHRS[i] inside {[8'h30:8'h39], [8'h41:8'h46]};
      mdl.mem[0] = CHRS[i];
      mdl.mem[1] = 8'h41;
      run(ascii_to_hex_op, 32'h0, 8'h02, 8'h00, 1'b0, 1'b0);
      check("ascii count", nel, ok ? 2 : 0);
      check("ascii flags", {enable_out, ill}, {ok, !ok});
    end
    for (i = 0; i < 6; i++) begin
      t = (i == 5) ? 255 : (i == 0) ? 0 : $urandom % 20;
      for (j = 0; j < 256; j++) begin
        f = 8'($urandom);
        mdl.mem[j] = (i % 2) ? f : exp_el(hex_to_ascii_op, f);
      end
      run((i % 2) ? hex_to_ascii_op : ascii_to_hex_op, 32'h0, 8'(t),
          8'h00, 1'b0, 1'b0);
      check("run count", nel, t);
      check("run flags", {enable_out, ill}, 2'b10);
    end
    for (i = 0; i < 45; i++) begin
      w = (i < 5) ? TXC[i][23:8] : 16'($urandom);
      // Upper format nibble held at zero by the sender
      f = {4'h0, 1'($urandom), 3'($urandom % 6)};
      if (i < 5) f = TXC[i][7:0];
      run(word_to_text_op, {16'h0, w}, 8'h00, f, 1'b0, 1'b0);
      check("text", text, txt(w, f[2:0], f[3]));
      check("text eno", {enable_out, ifmt, code}, 18'h20000);
    end
    for (i = 0; i < 4; i++) begin
      run(word_to_text_op, 32'h1234, 8'h00, FBAD[i], 1'b0, 1'b0);
      check("bad fmt", {enable_out, ifmt}, {1'b0, i >= 2});
      if (i < 2) check("space fill", text, {8{8'h20}});
    end
    finish_test();
  end
endmodule
